/* hdl/nv_ctrl_pkg.sv */
// Constants for the data nonvolatile memory erase and write controller
// Notes on behaviour
// - Mode bit high selects 16-byte page erase
// - Buffer cleared at reset and enable fall
// - Erase writes bump low nibble, saturate 0FH
// - Each page-mode data write tags address for erase
// - Erase timed internally, trigger self-clears
// - Erase end clears enable, tagged page bytes read zero
// - Write trigger without enable does nothing
// - Write timed internally, trigger self-clears
// - Byte write erases target byte first
// - Page buffer cleared on write-enable fall
// - Page write loads buffer, stops at 0FH
// - Write end clears write enable
// - Reset clears write enable and sector pointers
// - Cycle end sets done and multi-function flags
// - Vector needs all enables and stack room
// - Service clears multi flag and global only
// - Timing select bit picks cycle lengths
// - Erase trigger without enable does nothing
package nv_ctrl_pkg;
  localparam logic [2:0] ADDR_NVA  = 3'h0;
  localparam logic [2:0] ADDR_NVD  = 3'h1;
  localparam logic [2:0] ADDR_NVC  = 3'h2;
  localparam logic [2:0] ADDR_IRQ  = 3'h3;
  localparam logic [2:0] ADDR_PTRA = 3'h4;
  localparam logic [2:0] ADDR_PTRB = 3'h5;
  localparam logic [2:0] ADDR_MEMD = 3'h6;
  localparam int C_TSEL = 7;
  localparam int C_WIPE_EN = 6;
  localparam int C_WIPE_GO = 5;
  localparam int C_MODE = 4;
  localparam int C_PROG_EN = 3;
  localparam int C_PROG_GO = 2;
  localparam int I_GLOBAL = 0;
  localparam int I_NVEN = 1;
  localparam int I_MFEN = 2;
  localparam int I_DONE = 3;
  localparam int I_MFFLAG = 4;
  localparam int PAGE_BYTES = 16;
  localparam logic [3:0] PAGE_LAST = 4'hF;
  localparam logic [7:0] ERASED_VAL = 8'h00;
  localparam int CLK_HZ = 20_000_000;
  localparam int ERASE_A_US = 3200;
  localparam int WRITE_A_US = 2200;
  localparam int ERASE_B_US = 3700;
  localparam int WRITE_B_US = 3000;
  localparam int ERASE_A_CYC = ERASE_A_US * (CLK_HZ / 1_000_000);
  localparam int WRITE_A_CYC = WRITE_A_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_B_CYC = ERASE_B_US * (CLK_HZ / 1_000_000);
  localparam int WRITE_B_CYC = WRITE_B_US * (CLK_HZ / 1_000_000);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_WRITE = 3'b100
  } cyc_state_e;
endpackage

/* hdl/nv_cycle_timer.sv */
// Cycle timer counting down an erase or write duration
module nv_cycle_timer
  import nv_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Control
  input  wire logic        start_in,
  input  wire logic [17:0] length_in,
  output logic             done_out
);
  logic [17:0] count_q;
  logic        run_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q  <= 18'h0_0000;
      run_q    <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count_q <= length_in - 18'h0_0001;
        run_q   <= 1'b1;
      end else if (run_q) begin
        if (count_q == 18'h0_0000) begin
          run_q    <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_q <= count_q - 18'h0_0001;
        end
      end
    end
  end
endmodule

/* hdl/nv_erase_write_ctrl.sv */
// Data nonvolatile memory erase and write controller with page buffer
//
// Local design decisions: strobed register access and the placing of the registers.
module nv_erase_write_ctrl
  import nv_ctrl_pkg::*;
#(
  parameter int ERASE_A = ERASE_A_CYC,
  parameter int WRITE_A = WRITE_A_CYC,
  parameter int ERASE_B = ERASE_B_CYC,
  parameter int WRITE_B = WRITE_B_CYC
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register port
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Interrupt controller side
  input  wire logic       stack_full_in,
  input  wire logic       irq_ack_in,
  output logic            irq_vector_out,
  // Status
  output logic            busy_out
);
  logic [6:0]  nv_address_reg_q;
  logic [7:0]  nv_data_reg_q;
  logic [7:0]  nv_control_reg_q;
  logic [7:0]  sector_pointer_high_a_q;
  logic [7:0]  sector_pointer_high_b_q;
  logic        global_irq_enable_q;
  logic        nv_irq_enable_q;
  logic        mf_irq_enable_q;
  logic        nv_done_flag_q;
  logic        mf_flag_q;
  logic [7:0]  mem_q [0:127];
  logic [7:0]  buf_q [0:PAGE_BYTES-1];
  logic [15:0] tag_q;
  logic        wipe_enable_d1_q;
  logic        program_enable_d1_q;
  cyc_state_e  state_q;
  logic        wipe_enable;
  logic        wipe_start;
  logic        program_enable;
  logic        page_mode;
  logic        go_erase;
  logic        go_write;
  logic        done;
  logic [17:0] length;
  logic        data_wr;
  logic        buf_clear;
  logic [3:0]  low;

  assign wipe_enable    = nv_control_reg_q[C_WIPE_EN];
  assign wipe_start     = nv_control_reg_q[C_WIPE_GO];
  assign program_enable = nv_control_reg_q[C_PROG_EN];
  assign page_mode      = nv_control_reg_q[C_MODE];
  assign low            = nv_address_reg_q[3:0];
  assign data_wr        = wr_in && addr_in == ADDR_NVD
                          && state_q == ST_IDLE;
  // Trigger accepted only while its enable is already high
  assign go_erase = wr_in && addr_in == ADDR_NVC && state_q == ST_IDLE
                    && wipe_enable && wdata_in[C_WIPE_GO];
  assign go_write = wr_in && addr_in == ADDR_NVC && state_q == ST_IDLE
                    && program_enable && wdata_in[C_PROG_GO];
  // Enable falling edges empty the buffer
  assign buf_clear = (wipe_enable_d1_q && !wipe_enable)
                     || (program_enable_d1_q && !program_enable);

  always_comb begin
    if (nv_control_reg_q[C_TSEL]) begin
      length = go_erase ? 18'(ERASE_B) : 18'(WRITE_B);
    end else begin
      length = go_erase ? 18'(ERASE_A) : 18'(WRITE_A);
    end
  end

  nv_cycle_timer u_timer (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .start_in  (go_erase || go_write),
    .length_in (length),
    .done_out  (done)
  );

  // Cycle sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go_erase) begin
            state_q <= ST_ERASE;
          end else if (go_write) begin
            state_q <= ST_WRITE;
          end
        end
        ST_ERASE, ST_WRITE: begin
          if (done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Control register with self-clearing bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nv_control_reg_q <= 8'h00;
    end else if (done) begin
      nv_control_reg_q[C_WIPE_GO] <= 1'b0;
      nv_control_reg_q[C_PROG_GO] <= 1'b0;
      if (state_q == ST_ERASE) begin
        nv_control_reg_q[C_WIPE_EN] <= 1'b0;
      end else begin
        nv_control_reg_q[C_PROG_EN] <= 1'b0;
      end
    end else if (wr_in && addr_in == ADDR_NVC && state_q == ST_IDLE) begin
      nv_control_reg_q <= wdata_in;
      nv_control_reg_q[C_WIPE_GO] <= go_erase;
      nv_control_reg_q[C_PROG_GO] <= go_write;
    end
  end

  // Edge history of enables
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wipe_enable_d1_q    <= 1'b0;
      program_enable_d1_q <= 1'b0;
    end else begin
      wipe_enable_d1_q    <= wipe_enable;
      program_enable_d1_q <= program_enable;
    end
  end

  // Address and data registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nv_address_reg_q <= 7'h00;
      nv_data_reg_q    <= 8'h00;
    end else if (wr_in && addr_in == ADDR_NVA && state_q == ST_IDLE) begin
      nv_address_reg_q <= wdata_in[6:0];
    end else if (data_wr) begin
      nv_data_reg_q <= wdata_in;
      if (page_mode && low != PAGE_LAST) begin
        nv_address_reg_q[3:0] <= low + 4'h1;
      end
    end
  end

  // Page buffer and erase tags
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tag_q <= 16'h0000;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (buf_clear || (done && page_mode)) begin
      tag_q <= 16'h0000;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (data_wr && page_mode && !tag_q[low]) begin
      tag_q[low] <= 1'b1;
      buf_q[low] <= wdata_in;
    end
  end

  // Array update at end of cycle
  always_ff @(posedge clk_in) begin
    if (done && state_q == ST_ERASE && page_mode) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (tag_q[i]) begin
          mem_q[{nv_address_reg_q[6:4], 4'(i)}] <= ERASED_VAL;
        end
      end
    end else if (done && state_q == ST_WRITE && page_mode) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (tag_q[i]) begin
          mem_q[{nv_address_reg_q[6:4], 4'(i)}] <= buf_q[i];
        end
      end
    end else if (done && state_q == ST_WRITE) begin
      // Byte replaced whole, prior contents erased
      mem_q[nv_address_reg_q] <= nv_data_reg_q;
    end
  end

  // Interrupt flags and enables
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      global_irq_enable_q <= 1'b0;
      nv_irq_enable_q     <= 1'b0;
      mf_irq_enable_q     <= 1'b0;
      nv_done_flag_q      <= 1'b0;
      mf_flag_q           <= 1'b0;
    end else begin
      if (wr_in && addr_in == ADDR_IRQ) begin
        global_irq_enable_q <= wdata_in[I_GLOBAL];
        nv_irq_enable_q     <= wdata_in[I_NVEN];
        mf_irq_enable_q     <= wdata_in[I_MFEN];
        nv_done_flag_q      <= wdata_in[I_DONE] || done;
        mf_flag_q           <= wdata_in[I_MFFLAG] || done;
      end else begin
        if (irq_ack_in) begin
          mf_flag_q           <= 1'b0;
          global_irq_enable_q <= 1'b0;
        end
        // Cycle end wins over a service clear
        if (done) begin
          nv_done_flag_q <= 1'b1;
          mf_flag_q      <= 1'b1;
        end
      end
    end
  end

  // Memory sector pointers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sector_pointer_high_a_q <= 8'h00;
      sector_pointer_high_b_q <= 8'h00;
    end else if (wr_in && addr_in == ADDR_PTRA) begin
      sector_pointer_high_a_q <= wdata_in;
    end else if (wr_in && addr_in == ADDR_PTRB) begin
      sector_pointer_high_b_q <= wdata_in;
    end
  end

  // Outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_vector_out <= 1'b0;
      busy_out       <= 1'b0;
    end else begin
      irq_vector_out <= global_irq_enable_q && nv_irq_enable_q
                        && mf_irq_enable_q && mf_flag_q
                        && nv_done_flag_q && !stack_full_in;
      busy_out       <= state_q != ST_IDLE;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        ADDR_NVA:  rdata_out <= {1'b0, nv_address_reg_q};
        ADDR_NVD:  rdata_out <= nv_data_reg_q;
        ADDR_NVC:  rdata_out <= nv_control_reg_q;
        ADDR_IRQ:  rdata_out <= {3'h0, mf_flag_q, nv_done_flag_q,
                                 mf_irq_enable_q, nv_irq_enable_q,
                                 global_irq_enable_q};
        ADDR_PTRA: rdata_out <= sector_pointer_high_a_q;
        ADDR_PTRB: rdata_out <= sector_pointer_high_b_q;
        ADDR_MEMD: rdata_out <= mem_q[nv_address_reg_q];
        default:   rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Cycle length seen by the checks
  logic [17:0] run_len_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_len_q <= 18'h0_0000;
    end else if (state_q == ST_IDLE) begin
      run_len_q <= 18'h0_0000;
    end else begin
      run_len_q <= run_len_q + 18'h0_0001;
    end
  end

  chk_trig_needs_en: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $rose(state_q == ST_WRITE) |-> $past(program_enable))
    else $error("write started without enable");
  chk_erase_needs_en: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $rose(state_q == ST_ERASE) |-> $past(wipe_enable))
    else $error("erase started without enable");
  chk_done_clears: assert property (
    @(posedge clk_in) disable iff (rst_in)
    done && state_q == ST_ERASE |=> !wipe_start && !wipe_enable)
    else $error("erase end left bits set");
  chk_write_clears: assert property (
    @(posedge clk_in) disable iff (rst_in)
    done && state_q == ST_WRITE |=> !program_enable
    && !nv_control_reg_q[C_PROG_GO])
    else $error("write end left bits set");
  chk_flag_set: assert property (
    @(posedge clk_in) disable iff (rst_in)
    done |=> nv_done_flag_q && mf_flag_q)
    else $error("done flags not set");
  chk_addr_sat: assert property (
    @(posedge clk_in) disable iff (rst_in)
    data_wr && page_mode && low == PAGE_LAST |=> low == PAGE_LAST)
    else $error("address wrapped");
  chk_buf_clear: assert property (
    @(posedge clk_in) disable iff (rst_in)
    buf_clear |=> tag_q == 16'h0000)
    else $error("buffer not cleared");
  chk_vector_gate: assert property (
    @(posedge clk_in) disable iff (rst_in)
    irq_vector_out |-> $past(global_irq_enable_q && !stack_full_in))
    else $error("vector without enables");
  chk_wipe_fall: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $fell(wipe_enable) |=> tag_q == 16'h0000)
    else $error("buffer kept after erase enable fall");
  chk_addr_step: assert property (
    @(posedge clk_in) disable iff (rst_in)
    data_wr && page_mode && low != PAGE_LAST |=> low == $past(low) + 4'h1
    && nv_address_reg_q[6:4] == $past(nv_address_reg_q[6:4]))
    else $error("page address did not step");
  chk_erase_polls: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_q == ST_ERASE && !done |-> wipe_start)
    else $error("erase trigger dropped early");
  chk_write_polls: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_q == ST_WRITE && !done |-> nv_control_reg_q[C_PROG_GO])
    else $error("write trigger dropped early");
  chk_irq_service: assert property (
    @(posedge clk_in) disable iff (rst_in)
    irq_ack_in && !done && !(wr_in && addr_in == ADDR_IRQ) |=> !mf_flag_q
    && !global_irq_enable_q && $stable(nv_done_flag_q))
    else $error("service cleared wrong bits");
  chk_vector_full: assert property (
    @(posedge clk_in) disable iff (rst_in)
    irq_vector_out |-> $past(nv_irq_enable_q && mf_irq_enable_q && mf_flag_q))
    else $error("vector without source enables");
  chk_erase_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    done && state_q == ST_ERASE && page_mode && tag_q[0]
    |=> mem_q[{nv_address_reg_q[6:4], 4'h0}] == ERASED_VAL)
    else $error("erased byte not zero");
  chk_write_lands: assert property (
    @(posedge clk_in) disable iff (rst_in)
    done && state_q == ST_WRITE && !page_mode
    |=> mem_q[nv_address_reg_q] == $past(nv_data_reg_q))
    else $error("byte write lost");
  chk_erase_len: assert property (
    @(posedge clk_in) disable iff (rst_in)
    done && state_q == ST_ERASE |-> run_len_q
    == (nv_control_reg_q[C_TSEL] ? 18'(ERASE_B) : 18'(ERASE_A)))
    else $error("erase length wrong");
  chk_write_len: assert property (
    @(posedge clk_in) disable iff (rst_in)
    done && state_q == ST_WRITE |-> run_len_q
    == (nv_control_reg_q[C_TSEL] ? 18'(WRITE_B) : 18'(WRITE_A)))
    else $error("write length wrong");
  cov_erase: cover property (@(posedge clk_in) done && state_q == ST_ERASE);
  cov_write: cover property (@(posedge clk_in) done && state_q == ST_WRITE);
  cov_vector: cover property (@(posedge clk_in) irq_vector_out);
  cov_service: cover property (@(posedge clk_in) irq_ack_in && mf_flag_q);
  cov_page_full: cover property (@(posedge clk_in)
    data_wr && page_mode && low == PAGE_LAST);
endmodule

/* bench/tb_top.sv */
// Self-checking testbench for the erase and write controller
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("mismatch at %0t got %h expected %h", $time, (g), (e)); \
  end \
end

module tb_top
  import nv_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EA = 8;
  localparam int WA = 6;
  localparam int EB = 10;
  localparam int WB = 9;
  logic       clk_in;
  logic       rst_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       stack_full_in;
  logic       irq_ack_in;
  logic       irq_vector_out;
  logic       busy_out;
  int         n_errors;
  int         check_count;
  integer     seed;
  int         cnt_w [2];
  int         ce0;
  int         ce1;
  int         cw;
  logic [7:0] a;
  logic [7:0] d;
  logic [7:0] base;
  logic [7:0] exp_mem [16];

  nv_erase_write_ctrl #(
    .ERASE_A(EA),
    .WRITE_A(WA),
    .ERASE_B(EB),
    .WRITE_B(WB)
  ) dut (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .addr_in       (addr_in),
    .wdata_in      (wdata_in),
    .wr_in         (wr_in),
    .rd_in         (rd_in),
    .rdata_out     (rdata_out),
    .stack_full_in (stack_full_in),
    .irq_ack_in    (irq_ack_in),
    .irq_vector_out(irq_vector_out),
    .busy_out      (busy_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Idle control value for a timing choice
  function automatic logic [7:0] ctl(input int t);
    return (t != 0) ? 8'h80 : 8'h00;
  endfunction

  task automatic end_sim();
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] ra, input logic [7:0] wd);
    @(posedge clk_in);
    addr_in  <= ra;
    wdata_in <= wd;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] ra, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= ra;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out, e)
  endtask

  // Enable, trigger, then count busy cycles
  task automatic run(input logic [7:0] en, input logic [7:0] go,
                     output int n);
    int i;
    // Enable and trigger in consecutive cycles
    @(posedge clk_in);
    addr_in  <= ADDR_NVC;
    wdata_in <= en;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wdata_in <= go;
    @(posedge clk_in);
    wr_in <= 1'b0;
    n = 0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_in);
      #1;
      if (busy_out === 1'b1) n++;
      else if (n > 0) break;
    end
    if (i == 200 || n == 0) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic page_chk(input logic [7:0] b);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_NVA, b | 8'(i));
      rd_chk(ADDR_MEMD, exp_mem[i]);
    end
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    seed = 32'h6f0c_1ad6;
    rst_in = 1'b1;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    stack_full_in = 1'b0;
    irq_ack_in = 1'b0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) if (i != 6) rd_chk(3'(i), 8'h00);
    wr(ADDR_NVC, 8'h20);
    rd_chk(ADDR_NVC, 8'h00);
    wr(ADDR_NVC, 8'h04);
    rd_chk(ADDR_NVC, 8'h00);
    `CHK(busy_out, 1'b0)
    // Byte writes to one address under both timings
    a = 8'($random(seed)) & 8'h7F;
    for (int t = 0; t < 2; t++) begin
      d = 8'($random(seed));
      wr(ADDR_NVA, a);
      wr(ADDR_NVD, d);
      wr(ADDR_IRQ, 8'h00);
      run(ctl(t) | 8'h08, ctl(t) | 8'h0C, cnt_w[t]);
      rd_chk(ADDR_NVC, ctl(t));
      rd_chk(ADDR_IRQ, 8'h18);
      wr(ADDR_NVA, a);
      rd_chk(ADDR_MEMD, d);
    end
    `CHK(cnt_w[1] - cnt_w[0], WB - WA)
    // Interrupt vectoring and service
    @(posedge clk_in);
    stack_full_in <= 1'b1;
    wr(ADDR_IRQ, 8'h1F);
    repeat (3) @(posedge clk_in);
    stack_full_in <= 1'b0;
    #1;
    `CHK(irq_vector_out, 1'b0)
    repeat (3) @(posedge clk_in);
    irq_ack_in <= 1'b1;
    #1;
    `CHK(irq_vector_out, 1'b1)
    @(posedge clk_in);
    irq_ack_in <= 1'b0;
    rd_chk(ADDR_IRQ, 8'h0E);
    `CHK(irq_vector_out, 1'b0)
    // Full page erase
    base = 8'($random(seed)) & 8'h70;
    wr(ADDR_NVC, 8'h10);
    wr(ADDR_NVA, base);
    repeat (16) wr(ADDR_NVD, 8'($random(seed)));
    rd_chk(ADDR_NVA, base | 8'h0F);
    run(8'h50, 8'h70, ce0);
    rd_chk(ADDR_NVC, 8'h10);
    for (int i = 0; i < 16; i++) exp_mem[i] = 8'h00;
    page_chk(base);
    // Page write with one byte past the boundary
    wr(ADDR_NVA, base);
    for (int i = 0; i < 17; i++) begin
      d = 8'($random(seed));
      if (i < 16) exp_mem[i] = d;
      wr(ADDR_NVD, d);
    end
    rd_chk(ADDR_NVA, base | 8'h0F);
    run(8'h18, 8'h1C, cw);
    rd_chk(ADDR_NVC, 8'h10);
    page_chk(base);
    // Tags dropped by enable fall, then partial erase
    wr(ADDR_NVA, base);
    repeat (5) wr(ADDR_NVD, 8'($random(seed)));
    wr(ADDR_NVC, 8'hD0);
    wr(ADDR_NVC, 8'h90);
    wr(ADDR_NVA, base | 8'h05);
    repeat (3) wr(ADDR_NVD, 8'($random(seed)));
    run(8'hD0, 8'hF0, ce1);
    rd_chk(ADDR_NVC, 8'h90);
    for (int i = 5; i < 8; i++) exp_mem[i] = 8'h00;
    page_chk(base);
    `CHK(ce1 - ce0, EB - EA)
    // Page buffer cleared by write enable fall
    wr(ADDR_NVC, 8'h10);
    wr(ADDR_NVA, base);
    wr(ADDR_NVD, 8'hA5);
    wr(ADDR_NVD, 8'h5A);
    wr(ADDR_NVC, 8'h18);
    wr(ADDR_NVC, 8'h10);
    wr(ADDR_NVA, base | 8'h05);
    d = 8'($random(seed));
    exp_mem[5] = d;
    wr(ADDR_NVD, d);
    run(8'h18, 8'h1C, cw);
    page_chk(base);
    end_sim();
  end
endmodule
